// ### fwsr_bus_cycle.sv
`timescale 1ns/1ps
// one flash bus cycle: read (oe) or write (we) strobe with recovery
module fwsr_bus_cycle #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic              is_write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [DATA_W-1:0]      flash_dq_out,
    output logic                   flash_dq_oe,
    input  wire logic [DATA_W-1:0] flash_dq_in
);
    typedef enum logic [2:0] {
        BC_IDLE   = 3'b001,
        BC_STROBE = 3'b010,
        BC_GAP    = 3'b100
    } fwsr_bc_state_t;

    fwsr_bc_state_t state_ff;
    logic [3:0]     cnt_ff;
    logic           wr_ff;

    localparam logic [3:0] STROBE_LAST = 4'(fwsr_pkg::ACCESS_CYC > fwsr_pkg::PULSE_CYC ?
                                            fwsr_pkg::ACCESS_CYC : fwsr_pkg::PULSE_CYC);
    localparam logic [3:0] GAP_LAST    = 4'(fwsr_pkg::RECOVER_CYC);

    wire cnt_end = (state_ff == BC_STROBE) ? (cnt_ff == STROBE_LAST - 4'h1)
                                           : (cnt_ff == GAP_LAST - 4'h1);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff     <= BC_IDLE;
            cnt_ff       <= 4'h0;
            wr_ff        <= 1'b0;
            done         <= 1'b0;
            rdata        <= '0;
            flash_ce_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_addr   <= '0;
            flash_dq_out <= '0;
            flash_dq_oe  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_ff)
                BC_IDLE:
                begin
                    cnt_ff <= 4'h0;
                    if (start)
                    begin
                        state_ff     <= BC_STROBE;
                        wr_ff        <= is_write;
                        flash_addr   <= addr;
                        flash_dq_out <= wdata;
                        flash_dq_oe  <= is_write;
                        flash_ce_n   <= 1'b0;
                        flash_oe_n   <= is_write;
                        flash_we_n   <= ~is_write;
                    end
                end
                BC_STROBE:
                begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_end)
                    begin
                        // chip select and strobe both rise: ends the read or write cycle
                        if (!wr_ff)
                            rdata <= flash_dq_in;
                        flash_ce_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        flash_we_n <= 1'b1;
                        cnt_ff     <= 4'h0;
                        state_ff   <= BC_GAP;
                    end
                end
                BC_GAP:
                begin
                    flash_dq_oe <= 1'b0;
                    cnt_ff      <= cnt_ff + 4'h1;
                    if (cnt_end)
                    begin
                        done     <= 1'b1;
                        state_ff <= BC_IDLE;
                    end
                end
                default:
                    state_ff <= BC_IDLE;
            endcase
        end
    end
endmodule // fwsr_bus_cycle

// ### fwsr_ctrl.sv
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// RULE_01: in-progress toggle bit readable at any address once command sequence ends.
// RULE_02: in-progress bit inverts on each read while an algorithm runs.
// RULE_03: all-protected erase toggles 100 us, then array read.
// RULE_04: partly protected erase skips protected sectors silently.
// RULE_05: erase suspend stops the in-progress bit toggling.
// RULE_06: program to protected sector toggles about 2 us.
// RULE_07: erase-suspend program toggles until that program finishes.
// RULE_08: sector erase bit toggles on reads inside selected sectors.
// RULE_09: sector erase bit valid after final write pulse.
// RULE_10: host reads twice; unchanged toggle means done.
// RULE_11: persistent toggle: check time limit, recheck, on failure send reset.
// RULE_12: resumed polling restarts from the first double read.
// RULE_13: time-limit flag high when pulse-count limit exceeded.
// RULE_14: after time-limit failure only status works until reset.
// RULE_15: programming one over zero halts and sets time-limit flag.
// RULE_16: erase-window flag low during time-out, high once erase starts.
// RULE_17: window high ignores commands; low accepts more sector erases.
// RULE_18: host checks erase-window flag around each extra sector erase.
// RULE_19: ready/busy pin low while programming or erasing.
// RULE_20: ready/busy valid after final write strobe.
// RULE_21: query command accepted only in read-like modes.
// RULE_22: reset in query mode returns to the mode left.
// RULE_23: complement-poll bit shows inverse datum during programming.
// RULE_24: during erase time-out other commands return device to read.
// RULE_25: each toggle bit flips once per completed read cycle.
module fwsr_ctrl #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst,
    // classic wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // flash pins
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [DATA_W-1:0]      flash_dq_out,
    output logic                   flash_dq_oe,
    input  wire logic [DATA_W-1:0] flash_dq_in,
    input  wire logic              ready_busy_pin
);
    // ------------------------------------------------------------
    // poll state machine
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        PS_IDLE    = 7'b0000001,
        PS_READ1   = 7'b0000010,
        PS_READ2   = 7'b0000100,
        PS_RECHK1  = 7'b0001000,
        PS_RECHK2  = 7'b0010000,
        PS_RESET   = 7'b0100000,
        PS_SINGLE  = 7'b1000000
    } fwsr_poll_state_t;

    fwsr_poll_state_t state_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] first_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              bit_sel_ff;
    logic              done_ff;
    logic              fail_ff;
    logic              busy_ff;
    logic              rdy_ff;
    logic              window_ff;
    logic              tlimit_ff;
    logic              cyc_start_ff;
    logic              cyc_write_ff;
    logic [ADDR_W-1:0] cyc_addr_ff;
    logic [DATA_W-1:0] cyc_wdata_ff;

    wire               cyc_done;
    wire [DATA_W-1:0]  cyc_rdata;

    fwsr_bus_cycle #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_cycle (
        .clk          (clk),
        .rst          (rst),
        .start        (cyc_start_ff),
        .is_write     (cyc_write_ff),
        .addr         (cyc_addr_ff),
        .wdata        (cyc_wdata_ff),
        .done         (cyc_done),
        .rdata        (cyc_rdata),
        .flash_ce_n   (flash_ce_n),
        .flash_oe_n   (flash_oe_n),
        .flash_we_n   (flash_we_n),
        .flash_addr   (flash_addr),
        .flash_dq_out (flash_dq_out),
        .flash_dq_oe  (flash_dq_oe),
        .flash_dq_in  (flash_dq_in)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_ctrl   = wb_req & wb_we_i & (wb_adr_i == fwsr_pkg::ADDR_CTRL) & wb_sel_i[0];
    wire wr_addr   = wb_req & wb_we_i & (wb_adr_i == fwsr_pkg::ADDR_ADDR);
    wire wr_wdata  = wb_req & wb_we_i & (wb_adr_i == fwsr_pkg::ADDR_WDATA);
    wire idle      = (state_ff == PS_IDLE);
    wire go_poll   = wr_ctrl & idle & wb_dat_i[fwsr_pkg::CTRL_POLL_BIT];
    wire go_write  = wr_ctrl & idle & wb_dat_i[fwsr_pkg::CTRL_WRITE_BIT];
    wire go_read   = wr_ctrl & idle & wb_dat_i[fwsr_pkg::CTRL_READ_BIT];
    wire go_any    = go_poll | go_write | go_read;

    wire [ADDR_W-1:0] addr_next  = wr_addr ? wb_dat_i[ADDR_W-1:0] : addr_ff;
    wire [DATA_W-1:0] wdata_next = wr_wdata ? wb_dat_i[DATA_W-1:0] : wdata_ff;

    wire [31:0] status_word = {26'h0, tlimit_ff, window_ff, rdy_ff, fail_ff, done_ff, busy_ff};
    wire [31:0] rd_mux =
        (wb_adr_i == fwsr_pkg::ADDR_CTRL)   ? {31'h0, bit_sel_ff} << fwsr_pkg::CTRL_BIT_SEL :
        (wb_adr_i == fwsr_pkg::ADDR_ADDR)   ? 32'(addr_ff) :
        (wb_adr_i == fwsr_pkg::ADDR_WDATA)  ? 32'(wdata_ff) :
        (wb_adr_i == fwsr_pkg::ADDR_STATUS) ? status_word :
        (wb_adr_i == fwsr_pkg::ADDR_RDATA)  ? 32'(rdata_ff) : 32'h0;

    // toggle compare on the selected bit
    wire tpos_first = bit_sel_ff ? first_ff[fwsr_pkg::POS_SECTOR_ERASE]
                                 : first_ff[fwsr_pkg::POS_IN_PROGRESS];
    wire tpos_now   = bit_sel_ff ? cyc_rdata[fwsr_pkg::POS_SECTOR_ERASE]
                                 : cyc_rdata[fwsr_pkg::POS_IN_PROGRESS];
    wire toggling   = tpos_first ^ tpos_now;                         // [RULE_02] [RULE_08] [RULE_25]
    wire limit_hit  = cyc_rdata[fwsr_pkg::POS_TIME_LIMIT];           // [RULE_13] [RULE_15]

    // ------------------------------------------------------------
    // wishbone answer, one cycle after request
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            addr_ff  <= '0;
            wdata_ff <= '0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_mux : 32'h0;
            addr_ff  <= addr_next;
            wdata_ff <= wdata_next;
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff     <= PS_IDLE;
            first_ff     <= '0;
            rdata_ff     <= '0;
            bit_sel_ff   <= 1'b0;
            done_ff      <= 1'b0;
            fail_ff      <= 1'b0;
            busy_ff      <= 1'b0;
            rdy_ff       <= 1'b1;
            window_ff    <= 1'b0;
            tlimit_ff    <= 1'b0;
            cyc_start_ff <= 1'b0;
            cyc_write_ff <= 1'b0;
            cyc_addr_ff  <= '0;
            cyc_wdata_ff <= '0;
        end
        else
        begin
            cyc_start_ff <= 1'b0;
            rdy_ff       <= ready_busy_pin;                          // [RULE_19] [RULE_20]
            if (go_any)
            begin
                // every poll begins with a fresh double read
                busy_ff      <= 1'b1;
                done_ff      <= 1'b0;
                fail_ff      <= 1'b0;
                bit_sel_ff   <= wb_dat_i[fwsr_pkg::CTRL_BIT_SEL];
                cyc_start_ff <= 1'b1;
                cyc_write_ff <= go_write;
                cyc_addr_ff  <= addr_next;
                cyc_wdata_ff <= wdata_next;
                state_ff     <= go_poll ? PS_READ1 : PS_SINGLE;     // [RULE_12]
            end
            else if (cyc_done)
            begin
                case (state_ff)
                    PS_READ1, PS_RECHK1:
                    begin
                        first_ff     <= cyc_rdata;
                        cyc_start_ff <= 1'b1;
                        state_ff     <= (state_ff == PS_READ1) ? PS_READ2 : PS_RECHK2;
                    end
                    PS_READ2:
                    begin
                        rdata_ff  <= cyc_rdata;
                        window_ff <= cyc_rdata[fwsr_pkg::POS_ERASE_WINDOW]; // [RULE_16] [RULE_18]
                        tlimit_ff <= limit_hit;
                        if (!toggling)
                        begin
                            done_ff  <= 1'b1;                        // [RULE_10]
                            busy_ff  <= 1'b0;
                            state_ff <= PS_IDLE;
                        end
                        else if (limit_hit)
                        begin
                            cyc_start_ff <= 1'b1;                    // [RULE_11]
                            state_ff     <= PS_RECHK1;
                        end
                        else
                        begin
                            // keep polling; software may read status meanwhile
                            cyc_start_ff <= 1'b1;
                            state_ff     <= PS_READ1;
                        end
                    end
                    PS_RECHK2:
                    begin
                        rdata_ff <= cyc_rdata;
                        if (!toggling)
                        begin
                            done_ff  <= 1'b1;
                            busy_ff  <= 1'b0;
                            state_ff <= PS_IDLE;
                        end
                        else
                        begin
                            // failed algorithm: only a reset frees the device
                            fail_ff      <= 1'b1;                    // [RULE_11] [RULE_14]
                            cyc_write_ff <= 1'b1;
                            cyc_wdata_ff <= DATA_W'(fwsr_pkg::CMD_RESET);
                            cyc_start_ff <= 1'b1;
                            state_ff     <= PS_RESET;
                        end
                    end
                    PS_RESET:
                    begin
                        done_ff  <= 1'b1;
                        busy_ff  <= 1'b0;
                        state_ff <= PS_IDLE;
                    end
                    PS_SINGLE:
                    begin
                        if (!cyc_write_ff)
                            rdata_ff <= cyc_rdata;
                        done_ff  <= 1'b1;
                        busy_ff  <= 1'b0;
                        state_ff <= PS_IDLE;
                    end
                    default:
                        state_ff <= PS_IDLE;
                endcase
            end
        end
    end
endmodule // fwsr_ctrl

// ### fwsr_flash_model.sv
`timescale 1ns/1ps
module fwsr_flash_model #(
    parameter logic [15:0] ARRAY_WORD = 16'h5A3C
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [20:0] addr,
    input  wire logic [15:0] dq_out,
    input  wire logic        dq_oe,
    output logic [15:0]      dq_in,
    output logic             ready_busy_pin
);
    int          left = 0;
    int          tl_after = 0;
    int          n_reads = 0;
    logic        erase = 1'b0;
    logic        t6 = 1'b0;
    logic        t2 = 1'b0;
    logic        tl = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  last_cmd = 8'h00;
    logic [20:0] last_wa = '0;
    logic [15:0] last_dq = 16'h0000;
    logic        busy;
    logic [15:0] status;
    assign busy = left > 0 || tl_after > 0;
    assign status = {8'h00, erase ? 1'b0 : ~ARRAY_WORD[7], t6, tl, 1'b0, erase,
                     t2, 2'b00};
    // not selected: show the inverse so a stale value never looks valid
    assign dq_in = (!ce_n && !oe_n) ? (busy ? status : ARRAY_WORD) : ~last_dq;
    assign ready_busy_pin = busy ? 1'b0 : 1'b1;
    task automatic start_op(input int n, input int stuck, input logic ers);
        left = n;
        tl_after = stuck;
        erase = ers;
        tl = 1'b0;
        n_reads = 0;
    endtask
    always @(ce_n or oe_n or we_n or addr or dq_out or dq_oe)
    begin
        if (!ce_n && !oe_n)
            rd = 1'b1;
        else if (rd)
        begin
            rd = 1'b0;
            last_dq = busy ? status : ARRAY_WORD;
            n_reads++;
            if (busy)
            begin
                t6 = ~t6;
                if (erase)
                    t2 = ~t2;
                if (left > 0)
                    left--;
                if (tl_after > 0 && n_reads >= tl_after)
                    tl = 1'b1;
            end
        end
        if (!ce_n && !we_n && dq_oe)
        begin
            wr = 1'b1;
            last_cmd = dq_out[7:0];
            last_wa = addr;
        end
        else if (wr)
        begin
            wr = 1'b0;
            if (last_cmd == fwsr_pkg::CMD_RESET)
                start_op(0, 0, 1'b0);
            else if (erase && last_cmd == fwsr_pkg::CMD_ERASE_SUSP)
                left = 0;
        end
    end
endmodule // fwsr_flash_model

// ### fwsr_pkg.sv
package fwsr_pkg;
    // ------------------------------------------------------------
    // controller register map (byte addresses, 32-bit words)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_ADDR    = 8'h04;
    localparam logic [7:0] ADDR_WDATA   = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_RDATA   = 8'h10;

    // ctrl fields (write 1 to start)
    localparam int CTRL_POLL_BIT  = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_READ_BIT  = 2;
    localparam int CTRL_BIT_SEL   = 3;   // 0 = in-progress bit, 1 = sector erase bit

    // status fields
    localparam int ST_BUSY        = 0;
    localparam int ST_DONE        = 1;
    localparam int ST_FAIL        = 2;
    localparam int ST_RDY_PIN     = 3;
    localparam int ST_WINDOW      = 4;
    localparam int ST_TLIMIT      = 5;

    // status bit positions on the data bus lines
    localparam int POS_COMPLEMENT_POLL  = 7;
    localparam int POS_IN_PROGRESS      = 6;
    localparam int POS_TIME_LIMIT       = 5;
    localparam int POS_ERASE_WINDOW     = 3;
    localparam int POS_SECTOR_ERASE     = 2;

    // commands
    localparam logic [7:0] CMD_RESET        = 8'hF0;
    localparam logic [7:0] CMD_QUERY        = 8'h98;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_ERASE_SUSP   = 8'hB0;

    // ------------------------------------------------------------
    // bus cycle timing
    // ------------------------------------------------------------
    localparam int CLK_NS       = 50;
    localparam int ACCESS_NS    = 100;
    localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_NS     = 100;
    localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_NS   = 50;
    localparam int RECOVER_CYC  = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### fwsr_props.sv
`timescale 1ns/1ps
module fwsr_props #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              flash_ce_n,
    input wire logic              flash_oe_n,
    input wire logic              flash_we_n,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_dq_out,
    input wire logic              flash_dq_oe,
    input wire logic [DATA_W-1:0] flash_dq_in,
    input wire logic              ready_busy_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd_hold;
        (!flash_ce_n && !flash_oe_n) [*2];
    endsequence
    sequence s_idle;
        flash_ce_n && flash_oe_n && flash_we_n;
    endsequence
    property p_read_strobe;
        $fell(flash_oe_n) |-> s_rd_hold ##1 s_idle;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("bad read strobe");
    // separate cycles, so each read is a toggle event of its own
    property p_read_gap;
        $rose(flash_oe_n) |=> s_idle;
    endproperty
    a_read_gap: assert property (p_read_gap) else $error("no gap after read");
    property p_write_strobe;
        $fell(flash_we_n) |-> (!flash_ce_n && flash_dq_oe && flash_oe_n) [*2] ##1 flash_we_n;
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("bad write strobe");
    property p_no_fight;
        !flash_oe_n |-> !flash_dq_oe;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("driving bus while reading");
    property p_addr_hold;
        !flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_zero;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
endmodule // fwsr_props

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk;
    logic        rst;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat;
    logic [31:0] wb_dat_o;
    logic        wb_ack;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [20:0] f_addr;
    logic [15:0] f_dq_out;
    logic        f_dq_oe;
    logic [15:0] f_dq_in;
    logic        rdy_pin;
    logic [31:0] q;
    logic [20:0] a;
    int          errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          n;
    fwsr_ctrl #(.ADDR_W(21), .DATA_W(16)) dut (
        .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_addr(f_addr), .flash_dq_out(f_dq_out), .flash_dq_oe(f_dq_oe),
        .flash_dq_in(f_dq_in), .ready_busy_pin(rdy_pin));
    fwsr_flash_model flash (
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .dq_out(f_dq_out),
        .dq_oe(f_dq_oe), .dq_in(f_dq_in), .ready_busy_pin(rdy_pin));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            $display("MISMATCH t=%0t run hung", $time);
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    function automatic logic [31:0] exp_st(input logic done, input logic fail, input logic rdy);
        exp_st = 32'h0;
        exp_st[fwsr_pkg::ST_DONE] = done;
        exp_st[fwsr_pkg::ST_FAIL] = fail;
        exp_st[fwsr_pkg::ST_RDY_PIN] = rdy;
    endfunction
    // one classic cycle; waits for ack, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= ad;
        wb_dat <= d;
        @(posedge clk);
        while (wb_ack !== 1'b1 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 50)
        begin
            errors++;
            $display("MISMATCH t=%0t no ack", $time);
        end
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask
    // start an operation, then watch status until busy clears
    task automatic run_op(input logic [31:0] ctrl);
        int k;
        k = 0;
        wb(1'b1, fwsr_pkg::ADDR_CTRL, ctrl);
        q = 32'h1;
        while (q[fwsr_pkg::ST_BUSY] !== 1'b0 && k < 3000)
        begin
            wb(1'b0, fwsr_pkg::ADDR_STATUS, 32'h0);
            k++;
        end
        if (k >= 3000)
        begin
            errors++;
            $display("MISMATCH t=%0t poll never ended", $time);
        end
    endtask
    initial
    begin
        rst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_dat = 32'h0;
        void'($urandom(32'h227323a3));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, fwsr_pkg::ADDR_STATUS, 32'h0);
        chk(q & 32'hF, exp_st(1'b0, 1'b0, 1'b1), "status after reset");
        // bit select is latched only when an operation starts
        run_op(32'h9);
        wb(1'b0, fwsr_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'h8, "ctrl readback");
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0, "unmapped read");
        a = 21'($urandom);
        wb(1'b1, fwsr_pkg::ADDR_ADDR, 32'(a));
        wb(1'b1, fwsr_pkg::ADDR_WDATA, 32'(fwsr_pkg::CMD_QUERY));
        run_op(32'h2);
        chk(32'(flash.last_cmd), 32'(fwsr_pkg::CMD_QUERY), "written command");
        chk(32'(flash.last_wa), 32'(a), "written address");
        run_op(32'h4);
        wb(1'b0, fwsr_pkg::ADDR_RDATA, 32'h0);
        chk(q, 32'(flash.ARRAY_WORD), "single read data");
        // idle, program, erase, program on sector bit, stuck program
        for (int r = 0; r < 3; r++)
            for (int c = 0; c < 5; c++)
            begin
                n = 3 + ($urandom % 10);
                flash.start_op((c == 1 || c == 2) ? n : (c == 3 ? 20 : 0), c == 4 ? 4 : 0,
                               c == 2);
                // let the status register take up the new pin level
                @(posedge clk);
                wb(1'b0, fwsr_pkg::ADDR_STATUS, 32'h0);
                chk(32'(q[fwsr_pkg::ST_RDY_PIN]), 32'(c == 0), "ready pin status");
                run_op(32'h1 | ((c == 2 || c == 3) ? 32'h8 : 32'h0));
                chk(q & 32'h7, exp_st(1'b1, c == 4, 1'b0) & 32'h7, "poll result");
                if (c == 0 || c == 3)
                    chk(32'(flash.n_reads), 32'h2, "double read only");
                if (c == 1 || c == 2)
                    chk(32'(flash.n_reads >= n), 32'h1, "polled past end");
                if (c == 4)
                    chk(32'(flash.last_cmd), 32'(fwsr_pkg::CMD_RESET), "reset sent");
                flash.start_op(0, 0, 1'b0);
            end
        close_out();
    end
endmodule // testbench
bind fwsr_ctrl fwsr_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .ready_busy_pin(ready_busy_pin));
